//--- cid_regs.sv
`timescale 1ns/1ps
// How it works
// - Two read-only words, main at 0x0, extension at 0x4; writes ignored.
// - Main word bit 31 is one only when an extension word exists.
// - Extension word reads zero whenever the extension flag is clear.
// - Memory type: 0 ROM, 1 ROM-less, 2 flash, 3 ROM+flash, 4 SRAM.
// - With type 3 the first size is ROM, the second flash.
// - First size uses the 4-bit size code table.
// - Second size uses the same code; zero means no second memory.
// - RAM size uses its own 4-bit code table.
// - Revision field is a hard-wired silicon version.
module cid_regs #(
  parameter logic        P_EXT_PRESENT = 1'b0,
  parameter logic [2:0]  P_MEM_TYPE    = cid_pkg::MTYP_FLASH,
  parameter logic [7:0]  P_FAMILY      = 8'h5A,          // Arbitrary value
  parameter logic [3:0]  P_RAM_SIZE    = cid_pkg::RSZ_64K,
  parameter logic [3:0]  P_SIZE2       = cid_pkg::PSZ_NONE,
  parameter logic [3:0]  P_SIZE1       = cid_pkg::PSZ_512K,
  parameter logic [2:0]  P_CORE        = 3'h1,           // Arbitrary value
  parameter logic [4:0]  P_REVISION    = 5'h01,          // Arbitrary value
  parameter logic [31:0] P_EXT_VALUE   = 32'h0000_0001   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                        I_SYS_CLK,
  input  wire logic                        I_SRST,
  // Register port
  input  wire logic [cid_pkg::ADDR_W-1:0]  I_ADDR,
  input  wire logic [cid_pkg::DATA_W-1:0]  I_WDATA,
  input  wire logic                        I_WR,
  input  wire logic                        I_RD,
  output logic      [cid_pkg::DATA_W-1:0]  O_RDATA,
  // Status
  output logic                             O_SIZE_CODES_OK
);
  import cid_pkg::*;

  // ==========================================================================
  // Identity words
  wire [31:0] main_word;
  wire [31:0] ext_word;
  wire        ext_flag = P_EXT_PRESENT;

  assign main_word = {ext_flag,
                      P_MEM_TYPE,
                      P_FAMILY,
                      P_RAM_SIZE,
                      P_SIZE2,
                      P_SIZE1,
                      P_CORE,
                      P_REVISION};
  assign ext_word  = ext_flag ? P_EXT_VALUE : READ_ZERO;

  // ==========================================================================
  // Size code checks
  wire size1_ok;
  wire size2_ok;
  wire type_ok   = (P_MEM_TYPE <= MTYP_SRAM);
  wire second_ok = (P_MEM_TYPE != MTYP_ROM_FLASH) || (P_SIZE2 != PSZ_NONE);

  cid_field_chk u_chk1 (
    .i_code    (P_SIZE1),
    .i_none_ok (1'b1),
    .o_valid   (size1_ok)
  );

  cid_field_chk u_chk2 (
    .i_code    (P_SIZE2),
    .i_none_ok (1'b1),
    .o_valid   (size2_ok)
  );

  // ==========================================================================
  // Read decode; writes have no target
  wire        hit_main = (I_ADDR == OFF_ID_MAIN);
  wire        hit_ext  = (I_ADDR == OFF_ID_EXT);
  wire [31:0] rd_sel   = hit_main ? main_word :
                         hit_ext  ? ext_word  : READ_ZERO;

  cid_state_t state_q;
  cid_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ok_q;

  assign state_d = I_RD ? CID_ST_READ : CID_ST_IDLE;
  assign rdata_d = I_RD ? rd_sel : READ_ZERO;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      state_q <= CID_ST_IDLE;
      rdata_q <= READ_ZERO;
      ok_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      ok_q    <= size1_ok && size2_ok && type_ok && second_ok;
    end
  end

  assign O_RDATA         = rdata_q;
  assign O_SIZE_CODES_OK = ok_q;

  // ==========================================================================
  // Checks
  a_main_read: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && (I_ADDR == OFF_ID_MAIN) |=> O_RDATA == main_word)
    else $error("main word read wrong");
  a_ext_read: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && (I_ADDR == OFF_ID_EXT) |=> O_RDATA == ext_word)
    else $error("extension word read wrong");
  a_write_no_effect: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_WR ##1 I_RD && (I_ADDR == OFF_ID_MAIN) |=> O_RDATA == main_word)
    else $error("write altered identity");
  a_ext_flag_bit: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_main |=> O_RDATA[EXT_BIT] == P_EXT_PRESENT)
    else $error("extension flag wrong");
  a_ext_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_ext && !P_EXT_PRESENT |=> O_RDATA == READ_ZERO)
    else $error("extension not zero");
  a_type_field: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_main |=> O_RDATA[30:28] == P_MEM_TYPE)
    else $error("type field wrong");
  a_sizes_ok: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    $rose(ok_q) |-> size1_ok && size2_ok && second_ok)
    else $error("size status wrong");
  a_size1_field: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_main |=> O_RDATA[11:8] == P_SIZE1)
    else $error("first size wrong");
  a_size2_field: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_main |=> O_RDATA[15:12] == P_SIZE2)
    else $error("second size wrong");
  a_ram_field: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_main |=> O_RDATA[19:16] == P_RAM_SIZE)
    else $error("ram size wrong");
  a_rev_field: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_main |=> O_RDATA[4:0] == P_REVISION)
    else $error("revision wrong");
  a_layout_fields: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_RD && hit_main |=> O_RDATA[27:20] == P_FAMILY && O_RDATA[7:5] == P_CORE)
    else $error("layout wrong");
  a_idle_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !I_RD |=> O_RDATA == READ_ZERO && state_q == CID_ST_IDLE)
    else $error("data without read");

  c_read_main: cover property (@(posedge I_SYS_CLK) I_RD && hit_main);
  c_read_ext: cover property (@(posedge I_SYS_CLK) I_RD && hit_ext);
  c_read_unmapped: cover property (@(posedge I_SYS_CLK) I_RD && !hit_main && !hit_ext);
  c_back_to_back: cover property (@(posedge I_SYS_CLK) I_RD ##1 I_RD);

endmodule

//--- cid_pkg.sv
package cid_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 32;
  localparam logic [7:0]  OFF_ID_MAIN     = 8'h00;
  localparam logic [7:0]  OFF_ID_EXT      = 8'h04;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  // ==========================================================================
  // Main identity word field positions
  localparam int unsigned EXT_BIT         = 31;
  localparam int unsigned TYPE_LSB        = 28;
  localparam int unsigned FAMILY_LSB      = 20;
  localparam int unsigned RAM_LSB         = 16;
  localparam int unsigned SIZE2_LSB       = 12;
  localparam int unsigned SIZE1_LSB       = 8;
  localparam int unsigned CORE_LSB        = 5;
  localparam int unsigned REV_LSB         = 0;

  // ==========================================================================
  // Program memory type codes
  localparam logic [2:0]  MTYP_ROM        = 3'h0;
  localparam logic [2:0]  MTYP_ROMLESS    = 3'h1;
  localparam logic [2:0]  MTYP_FLASH      = 3'h2;
  localparam logic [2:0]  MTYP_ROM_FLASH  = 3'h3;
  localparam logic [2:0]  MTYP_SRAM       = 3'h4;

  // ==========================================================================
  // Program memory size codes (bytes)
  localparam logic [3:0]  PSZ_NONE        = 4'h0;
  localparam logic [3:0]  PSZ_8K          = 4'h1;
  localparam logic [3:0]  PSZ_16K         = 4'h2;
  localparam logic [3:0]  PSZ_32K         = 4'h3;
  localparam logic [3:0]  PSZ_64K         = 4'h5;
  localparam logic [3:0]  PSZ_128K        = 4'h7;
  localparam logic [3:0]  PSZ_256K        = 4'h9;
  localparam logic [3:0]  PSZ_512K        = 4'hA;
  localparam logic [3:0]  PSZ_1024K       = 4'hC;
  localparam logic [3:0]  PSZ_2048K       = 4'hE;

  // ==========================================================================
  // Internal RAM size codes (bytes)
  localparam logic [3:0]  RSZ_48K         = 4'h0;
  localparam logic [3:0]  RSZ_16K         = 4'h9;
  localparam logic [3:0]  RSZ_64K         = 4'hB;

  // ==========================================================================
  // Bus slave states
  typedef enum logic [1:0] {
    CID_ST_IDLE = 2'b01,
    CID_ST_READ = 2'b10
  } cid_state_t;

endpackage

//--- cid_field_chk.sv
`timescale 1ns/1ps
// Flags whether a 4-bit size code is a defined program memory size, or is PSZ_NONE while i_none_ok is set
module cid_field_chk (
  // Code
  input  wire logic [3:0] i_code,
  input  wire logic       i_none_ok,
  // Result
  output logic            o_valid
);
  import cid_pkg::*;

  wire is_none = (i_code == PSZ_NONE);
  wire is_size = (i_code == PSZ_8K)   || (i_code == PSZ_16K)   || (i_code == PSZ_32K)  ||
                 (i_code == PSZ_64K)  || (i_code == PSZ_128K)  || (i_code == PSZ_256K) ||
                 (i_code == PSZ_512K) || (i_code == PSZ_1024K) || (i_code == PSZ_2048K);

  assign o_valid = is_size || (is_none && i_none_ok);

endmodule

//--- cid_regs_bench.sv
`timescale 1ns/1ps
module cid_regs_bench;
  import cid_pkg::*;
  // ==========================================================================
  // Expected words, built field by field
  localparam logic [31:0] EXP_A = {1'b0, MTYP_FLASH, 8'h5A, RSZ_64K, PSZ_NONE, PSZ_512K,
                                   3'h1, 5'h01};
  localparam logic [31:0] EXP_B = {1'b1, MTYP_ROM_FLASH, 8'hC3, RSZ_48K, PSZ_2048K, PSZ_16K,
                                   3'h2, 5'h1F};
  localparam logic [31:0] EXT_B = 32'hA5C3_0F96;  // Arbitrary value
  logic        clk;
  logic        srst;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] da;
  logic [31:0] db;
  wire  logic [31:0] rdata_a;
  wire  logic [31:0] rdata_b;
  wire  logic        ok_a;
  wire  logic        ok_b;
  int          n_mismatch;
  int          checked;
  int          cycles;
  // ==========================================================================
  // Devices: defaults, and one with an extension word and ROM plus flash
  cid_regs cid_regs_i (.I_SYS_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata_a), .O_SIZE_CODES_OK(ok_a));
  cid_regs #(.P_EXT_PRESENT(1'b1), .P_MEM_TYPE(MTYP_ROM_FLASH), .P_FAMILY(8'hC3),
    .P_RAM_SIZE(RSZ_48K), .P_SIZE2(PSZ_2048K), .P_SIZE1(PSZ_16K), .P_CORE(3'h2),
    .P_REVISION(5'h1F), .P_EXT_VALUE(EXT_B)) cid_regs_ext_i (.I_SYS_CLK(clk),
    .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata_b), .O_SIZE_CODES_OK(ok_b));
  // ==========================================================================
  // Clock, timeout and closing
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // ==========================================================================
  // Bus cycles
  task automatic rd_word(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    da = rdata_a;
    db = rdata_b;
  endtask
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_fields();
    rd_word(OFF_ID_MAIN);
    cmp(da, EXP_A, "main word A");
    cmp(db, EXP_B, "main word B");
    cmp({28'h000_0000, db[15:8]}, {28'h000_0000, PSZ_2048K, PSZ_16K}, "sizes B");
    rd_word(OFF_ID_EXT);
    cmp(da, READ_ZERO, "ext word A");
    cmp(db, EXT_B, "ext word B");
  endtask
  task automatic t_write();
    wr_word(OFF_ID_MAIN, 32'hFFFF_FFFF);
    wr_word(OFF_ID_EXT, 32'h0000_0000);
    rd_word(OFF_ID_MAIN);
    cmp(da, EXP_A, "main after write");
    rd_word(OFF_ID_EXT);
    cmp(db, EXT_B, "ext after write");
  endtask
  task automatic t_back_to_back();
    @(posedge clk);
    rd <= 1'b1;
    addr <= OFF_ID_EXT;
    @(posedge clk);
    addr <= 8'h08;
    #1;
    cmp(rdata_b, EXT_B, "first of pair");
    @(posedge clk);
    addr <= OFF_ID_MAIN;
    #1;
    cmp(rdata_b, READ_ZERO, "unmapped read");
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata_b, EXP_B, "third of run");
    @(posedge clk);
    #1;
    cmp(rdata_a, READ_ZERO, "idle data");
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {srst, wr, rd, addr, wdata} = '0;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    cmp(rdata_a, READ_ZERO, "data in reset");
    cmp_flag(ok_b, 1'b0, "status in reset");
    repeat (3) @(posedge clk);
    #1;
    cmp_flag(ok_a, 1'b1, "status A");
    cmp_flag(ok_b, 1'b1, "status B");
    t_fields();
    t_write();
    t_back_to_back();
    stop_test();
  end
endmodule
